// [verilog/bus_req_cfg.svh]
// constants for the request-phase address block
// assumes inclusion by bare name from design files
`ifndef BUS_REQ_CFG_SVH
`define BUS_REQ_CFG_SVH
`define ADDR_HI_BIT     35
`define ADDR_LO_BIT     3
`define ADDR_W          33
`define A20_IDX         17
`define AP_HI_LO        21
`define CFG_ADDR_PARITY_ERR_N_EN_IDX 0
`define CFG_RESET_VAL   33'h000000000
`define SYNC_RESET_VAL  3'h7
`endif

// [verilog/bus_req_pkg.sv]
// types for the request-phase address block
// assumes bus_req_cfg.svh is found on the include path
`include "bus_req_cfg.svh"
package bus_req_pkg;
	typedef logic [`ADDR_W-1:0] addr_t;	// line 0 is address bit 3
	typedef struct packed {
		logic  valid;	// request wanted
		addr_t addr;	// physical address 35:3
		addr_t ttype;	// type info for the next cycle
	} req_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ADDR = 2'b01,
		ST_TYPE = 2'b11
	} req_state_t;
endpackage

// [verilog/pin_sync3.sv]
// three-flop synchroniser with agreement check
// assumes one clock, async active-low reset
`timescale 1ns/100ps
module pin_sync3 #(
	parameter logic RESET_VAL = 1'b1
) (
	// clock and reset
	input  wire logic core_clk,
	input  wire logic arst_n,
	// pin side
	input  wire logic pin_in,
	// core side
	output logic      level
);
	logic s1;	// metastable stage, read only by s2
	logic s2;	// second stage
	logic s3;	// third stage
	// shift chain
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			s1 <= RESET_VAL;
			s2 <= RESET_VAL;
			s3 <= RESET_VAL;
		end else begin
			s1 <= pin_in;
			s2 <= s1;
			s3 <= s2;
		end
	end
	// change counts once stage two and three agree
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			level <= RESET_VAL;
		end else if (s2 == s3) begin
			level <= s3;
		end
	end
endmodule

// [verilog/bus_req_addr.sv]
// request-phase address, parity, reset strap, error abort, trip
// assumes core_clk is the bus clock and the pad wire is resolved outside
`timescale 1ns/100ps
`include "bus_req_cfg.svh"
module bus_req_addr
	import bus_req_pkg::*;
(
	// clock and reset
	input  wire logic  core_clk,
	input  wire logic  arst_n,
	// core request side
	input  wire req_t  req,
	output logic       req_ready,
	output logic       req_abort,
	output logic       new_txn,
	// address pins, low active
	input  wire addr_t addr_in_n,
	output addr_t      addr_out_n,
	output logic       addr_oe,
	// strobe pin
	input  wire logic  addr_strobe_in_n,
	output logic       addr_strobe_out_n,
	output logic       addr_strobe_oe,
	// parity pins
	output logic [1:0] addr_parity_n,
	output logic       addr_parity_oe,
	// error and mask pins
	input  wire logic  addr_parity_err_n,
	input  wire logic  addr_bit20_mask_n,
	// power-on configuration
	input  wire logic  bus_reset_n,
	output addr_t      poc_cfg,
	// thermal
	input  wire logic  overheat,
	input  wire logic  core_rail_ok,
	input  wire logic  term_rail_ok,
	output logic       overheat_trip_n,
	output logic       overheat_trip_oe
);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// parity of low-active lines: high when even number are low
	function automatic logic par_n(input logic [`ADDR_W-1:0] v,
		input logic [`ADDR_W-1:0] m);
		par_n = ~^(~v & m);
	endfunction
	localparam addr_t HI_MASK = {{12{1'b1}}, {21{1'b0}}};
	localparam addr_t LO_MASK = {{12{1'b0}}, {21{1'b1}}};

	// ------------------------------------------------------------
	// synchronised pins
	// ------------------------------------------------------------
	logic mask_n_s;	// address-20 mask, synchronised
	logic rst_n_s;	// bus reset, synchronised
	logic rst_n_d;	// previous reset level
	pin_sync3 #(.RESET_VAL(1'b1)) u_mask (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.pin_in   (addr_bit20_mask_n),
		.level    (mask_n_s)
	);
	pin_sync3 #(.RESET_VAL(1'b0)) u_rst (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.pin_in   (bus_reset_n),
		.level    (rst_n_s)
	);
	// rail status comes from the power logic, not from this clock
	logic core_ok_s;	// core rail present, synchronised
	logic term_ok_s;	// termination rail present, synchronised
	pin_sync3 #(.RESET_VAL(1'b1)) u_core_ok (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.pin_in   (core_rail_ok),
		.level    (core_ok_s)
	);
	pin_sync3 #(.RESET_VAL(1'b1)) u_term_ok (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.pin_in   (term_rail_ok),
		.level    (term_ok_s)
	);

	// ------------------------------------------------------------
	// power-on configuration strap
	// ------------------------------------------------------------
	// reset edge tracker
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_n_d <= 1'b0;
		end else begin
			rst_n_d <= rst_n_s;
		end
	end
	// sample lines on reset release, active-high view
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			poc_cfg <= `CFG_RESET_VAL;
		end else if (rst_n_s && !rst_n_d) begin
			poc_cfg <= ~addr_in_n;
		end
	end
	logic addr_parity_err_n_en;	// parity error observation enabled
	assign addr_parity_err_n_en = poc_cfg[`CFG_ADDR_PARITY_ERR_N_EN_IDX];

	// ------------------------------------------------------------
	// request sequencer
	// ------------------------------------------------------------
	req_state_t state;	// current phase
	req_state_t next_state;	// next phase
	addr_t      ttype_q;	// held type info
	logic       err_hit;	// abort condition
	assign err_hit = addr_parity_err_n_en && !addr_parity_err_n && state != ST_IDLE;
	assign req_ready = (state == ST_IDLE) && rst_n_s;
	// phase choice
	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: if (req.valid && req_ready) next_state = ST_ADDR;
			ST_ADDR: next_state = err_hit ? ST_IDLE : ST_TYPE;
			ST_TYPE: next_state = ST_IDLE;
		endcase
	end
	// phase register
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= ST_IDLE;
		end else if (!rst_n_s) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end
	// pin drive, one cycle address then one cycle type unless aborted
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			addr_out_n        <= '1;
			addr_strobe_out_n <= 1'b1;
			addr_oe           <= 1'b0;
			addr_parity_n     <= 2'h3;
			ttype_q           <= '0;
		end else if (next_state == ST_ADDR) begin
			addr_strobe_out_n <= 1'b0;
			addr_oe           <= 1'b1;
			ttype_q           <= req.ttype;
			// masked address and its parity together
			addr_out_n <= ~masked(req.addr);
			addr_parity_n <= {par_n(~masked(req.addr), HI_MASK),
				par_n(~masked(req.addr), LO_MASK)};
		end else if (next_state == ST_TYPE) begin
			addr_strobe_out_n <= 1'b1;
			addr_out_n        <= ~ttype_q;
		end else begin
			addr_strobe_out_n <= 1'b1;
			addr_oe           <= 1'b0;
			addr_out_n        <= '1;
			addr_parity_n     <= 2'h3;
		end
	end
	// mask bit 20 when the mask is asserted
	function automatic addr_t masked(input addr_t a);
		masked = a;
		if (!mask_n_s) masked[`A20_IDX] = 1'b0;
	endfunction
	assign addr_strobe_oe = addr_oe;
	assign addr_parity_oe = (state == ST_ADDR);
	assign req_abort      = err_hit;
	// any agent's strobe starts a transaction
	logic strobe_d;	// last sampled strobe
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			strobe_d <= 1'b1;
		end else begin
			strobe_d <= addr_strobe_in_n;
		end
	end
	assign new_txn = strobe_d && !addr_strobe_in_n;

	// ------------------------------------------------------------
	// over-temperature trip
	// ------------------------------------------------------------
	logic trip;	// trip latched
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			trip <= 1'b0;
		end else if (!core_ok_s && !term_ok_s) begin
			trip <= 1'b0;
		end else if (overheat) begin
			trip <= 1'b1;
		end
	end
	assign overheat_trip_n  = 1'b0;
	assign overheat_trip_oe = trip;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	par_check_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		addr_parity_oe |-> addr_parity_n[1] ==
		par_n(addr_out_n, HI_MASK)) else $error("hi parity wrong");
	par_lo_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		addr_parity_oe |-> addr_parity_n[0] ==
		par_n(addr_out_n, LO_MASK)) else $error("lo parity wrong");
	strobe_par_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		!addr_strobe_out_n |-> addr_parity_oe && addr_oe)
		else $error("parity not with strobe");
	mask_a20_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(next_state == ST_ADDR && !mask_n_s) |=> addr_out_n[`A20_IDX])
		else $error("bit 20 not masked");
	type_follow_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(state == ST_ADDR && !err_hit) |=> addr_strobe_out_n &&
		addr_out_n == ~$past(ttype_q)) else $error("type phase");
	strap_cap_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		$rose(rst_n_s) |=> poc_cfg == ~$past(addr_in_n))
		else $error("strap missed");
	abort_en_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		req_abort |-> addr_parity_err_n_en) else $error("abort while disabled");
	abort_idle_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(req_abort && state == ST_ADDR) |=> state == ST_IDLE)
		else $error("abort ignored");
	trip_off_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(!core_ok_s && !term_ok_s) |=> !overheat_trip_oe)
		else $error("trip held");
	new_txn_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(state == ST_ADDR && !addr_strobe_in_n) |-> new_txn)
		else $error("start missed");
	req_c: cover property (@(posedge core_clk) state == ST_TYPE);
	abort_c: cover property (@(posedge core_clk) req_abort);
	trip_c: cover property (@(posedge core_clk) $fell(overheat_trip_oe));
	mask_c: cover property (@(posedge core_clk) addr_strobe_oe && !mask_n_s);
endmodule

// [dv/bus_agent_model.sv]
// far-side bus agent and system power logic model
// assumes pull-ups on idle address and strobe lines
`timescale 1ns/100ps
module bus_agent_model
	import bus_req_pkg::*;
#(
	parameter int RAIL_DLY = 4	// stands for the rail drop time
) (
	// clock
	input  wire logic  core_clk,
	// device pins
	input  wire addr_t addr_out_n,
	input  wire logic  addr_oe,
	input  wire logic  addr_strobe_out_n,
	input  wire logic  addr_strobe_oe,
	input  wire logic  overheat_trip_oe,
	output addr_t      addr_in_n,
	output logic       addr_strobe_in_n,
	output logic       core_rail_ok,
	output logic       term_rail_ok,
	// bench control
	input  wire logic  strap_en,
	input  wire addr_t strap
);
	int   cnt;	// cycles since trip seen
	logic off;	// latched power-off
	// --------------------------------
	// wire resolution
	// --------------------------------
	// strap while strap_en is set, else device or pull-up
	assign addr_in_n = strap_en ? ~strap :
		(addr_oe ? addr_out_n : '1);
	assign addr_strobe_in_n = addr_strobe_oe ? addr_strobe_out_n : 1'b1;
	// --------------------------------
	// power logic
	// --------------------------------
	// drop both rails, latched against re-enable
	always @(posedge core_clk) begin
		if (overheat_trip_oe && !off)
			cnt <= cnt + 1;
		if (cnt >= RAIL_DLY)
			off <= 1'b1;
	end
	assign core_rail_ok = !off;
	assign term_rail_ok = !off;
	initial begin
		cnt = 0;
		off = 1'b0;
	end
endmodule

// [dv/bus_req_addr_tb_top.sv]
// bench for the request-phase address block
// assumes the design package and header on the include path
`timescale 1ns/100ps
`include "bus_req_cfg.svh"
module bus_req_addr_tb_top
	import bus_req_pkg::*;
;
	logic core_clk, arst_n, req_ready, req_abort, new_txn, addr_oe;
	logic addr_strobe_in_n, addr_strobe_out_n, addr_strobe_oe;
	logic addr_parity_oe, addr_parity_err_n, addr_bit20_mask_n;
	logic bus_reset_n, overheat, core_rail_ok, term_rail_ok;
	logic overheat_trip_n, overheat_trip_oe, strap_en;
	logic [1:0] addr_parity_n;
	req_t       req;
	addr_t      addr_in_n, addr_out_n, poc_cfg, strap, cur;
	int         fails = 0, num_checks = 0;
	bus_req_addr u_dut (
		.core_clk          (core_clk),
		.arst_n            (arst_n),
		.req               (req),
		.req_ready         (req_ready),
		.req_abort         (req_abort),
		.new_txn           (new_txn),
		.addr_in_n         (addr_in_n),
		.addr_out_n        (addr_out_n),
		.addr_oe           (addr_oe),
		.addr_strobe_in_n  (addr_strobe_in_n),
		.addr_strobe_out_n (addr_strobe_out_n),
		.addr_strobe_oe    (addr_strobe_oe),
		.addr_parity_n     (addr_parity_n),
		.addr_parity_oe    (addr_parity_oe),
		.addr_parity_err_n (addr_parity_err_n),
		.addr_bit20_mask_n (addr_bit20_mask_n),
		.bus_reset_n       (bus_reset_n),
		.poc_cfg           (poc_cfg),
		.overheat          (overheat),
		.core_rail_ok      (core_rail_ok),
		.term_rail_ok      (term_rail_ok),
		.overheat_trip_n   (overheat_trip_n),
		.overheat_trip_oe  (overheat_trip_oe)
	);
	bus_agent_model u_agent (
		.core_clk          (core_clk),
		.addr_out_n        (addr_out_n),
		.addr_oe           (addr_oe),
		.addr_strobe_out_n (addr_strobe_out_n),
		.addr_strobe_oe    (addr_strobe_oe),
		.overheat_trip_oe  (overheat_trip_oe),
		.addr_in_n         (addr_in_n),
		.addr_strobe_in_n  (addr_strobe_in_n),
		.core_rail_ok      (core_rail_ok),
		.term_rail_ok      (term_rail_ok),
		.strap_en          (strap_en),
		.strap             (strap)
	);
	always #4 core_clk = ~core_clk;
	// --------------------------------
	// compare and report
	// --------------------------------
	task automatic cmp_a(input addr_t g, input addr_t e, input string m);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("unexpected %0t %s", $time, m);
		end
	endtask
	task automatic cmp_b(input logic g, input logic e, input string m);
		cmp_a({32'h0, g}, {32'h0, e}, m);
	endtask
	task automatic final_report();
		if (fails == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// --------------------------------
	// scenarios
	// --------------------------------
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge core_clk);
			#1;
			n++;
		end while (req_ready !== 1'b1 && n < 50);
		cmp_b(req_ready, 1'b1, "ready");
	endtask
	// bus reset with a strap pattern on the lines
	task automatic do_strap(input addr_t s);
		@(posedge core_clk);
		strap <= s;
		strap_en <= 1'b1;
		bus_reset_n <= 1'b0;
		repeat (5) @(posedge core_clk);
		bus_reset_n <= 1'b1;
		wait_ready();
		@(posedge core_clk);
		strap_en <= 1'b0;
		cur = s;
		#1;
		cmp_a(poc_cfg, s, "strap");
	endtask
	// one request, optional parity error in the strobe cycle
	task automatic send(input addr_t a, input addr_t t, input logic perr);
		addr_t m;
		logic  ab;
		m = a;
		if (addr_bit20_mask_n === 1'b0)
			m[`A20_IDX] = 1'b0;
		ab = perr & cur[`CFG_ADDR_PARITY_ERR_N_EN_IDX];
		wait_ready();
		@(posedge core_clk);
		req <= '{1'b1, a, t};
		@(posedge core_clk);
		req.valid <= 1'b0;
		addr_parity_err_n <= ~perr;
		#1;
		cmp_b(addr_strobe_out_n | ~addr_oe, 1'b0, "strobe");
		cmp_a(addr_out_n, ~m, "address");
		cmp_b(addr_parity_n[1], ~^m[32:21], "par hi");
		cmp_b(addr_parity_n[0], ~^m[20:0], "par lo");
		cmp_b(addr_parity_oe & addr_strobe_oe, 1'b1, "par oe");
		cmp_b(new_txn, 1'b1, "new txn");
		cmp_b(req_abort, ab, "abort");
		@(posedge core_clk);
		addr_parity_err_n <= 1'b1;
		#1;
		if (!ab) begin
			cmp_a(addr_out_n, ~t, "type");
			cmp_b(addr_strobe_out_n, 1'b1, "strobe off");
		end else begin
			cmp_b(addr_oe, 1'b0, "abort idle");
		end
	endtask
	// trip on, rails drop, trip released
	task automatic trip();
		int n;
		@(posedge core_clk);
		overheat <= 1'b1;
		repeat (2) @(posedge core_clk);
		#1;
		cmp_b(overheat_trip_oe & ~overheat_trip_n, 1'b1, "trip");
		n = 0;
		while (overheat_trip_oe === 1'b1 && n < 20) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		cmp_b(overheat_trip_oe, 1'b0, "trip off");
		cmp_b(core_rail_ok | term_rail_ok, 1'b0, "rails");
	endtask
	// --------------------------------
	// main sequence and watchdog
	// --------------------------------
	initial begin
		core_clk = 1'b0;
		arst_n = 1'b0;
		req = '0;
		addr_parity_err_n = 1'b1;
		addr_bit20_mask_n = 1'b1;
		bus_reset_n = 1'b0;
		overheat = 1'b0;
		strap_en = 1'b1;
		strap = '0;
		cur = '0;
		repeat (3) @(posedge core_clk);
		arst_n <= 1'b1;
		do_strap(33'h1_2345_6789);
		send('1, 33'h0_0000_0005, 1'b0);
		send(33'h1_F000_0000, 33'h1_0FFF_FFFF, 1'b0);
		send(33'h0_0E00_0001, '0, 1'b1);
		do_strap(33'h0_A5A5_A5A4);
		send(33'h0_1234_5678, 33'h1_8765_4321, 1'b1);
		addr_bit20_mask_n <= 1'b0;
		repeat (6) @(posedge core_clk);
		send('1, 33'h0_0000_0003, 1'b0);
		trip();
		final_report();
	end
	initial begin
		#(3000 * 8);
		fails++;
		final_report();
	end
endmodule
